//--- bench/rv_in_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// pair of redundant input modules sharing one signal
// ----------------------------------------
module rv_in_model (
	input wire logic [15:0] real_di,
	input wire logic [15:0] glitch_a,
	input wire logic [15:0] stuck_hi_a,
	input wire logic [15:0] stuck_lo_b,
	input wire logic [15:0] ana_a,
	input wire logic [15:0] ana_b,
	output logic [15:0] di_a,
	output logic [15:0] di_b,
	output rv_pkg::rv_ana_pair_t ana_in
);
	// both sides track the signal; faults appear only where a test injects them
	assign di_a = (real_di ^ glitch_a) | stuck_hi_a;
	assign di_b = real_di & ~stuck_lo_b;
	assign ana_in = {ana_a, ana_b};
endmodule

//--- bench/tb.sv
`timescale 1ns/10ps
`include "rv_cfg.svh"
module tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic irq;
	logic [31:0] hrdata;
	logic eval_tick = 1'b0;
	logic handler = 1'b0;
	logic [15:0] real_di = 16'h0;
	logic [15:0] glitch_a = 16'h0;
	logic [15:0] stuck_hi_a = 16'h0;
	logic [15:0] stuck_lo_b = 16'h0;
	logic [15:0] ana_a = 16'h0;
	logic [15:0] ana_b = 16'h0;
	logic [15:0] di_a;
	logic [15:0] di_b;
	logic [15:0] di_image;
	logic [15:0] ana_image;
	rv_pkg::rv_ana_pair_t ana_in;
	int n_fail = 0;
	int n_compared = 0;
	logic [31:0] rd;

	assign hready = hreadyout;

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	rv_voter i_rv_voter (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .eval_tick(eval_tick), .di_a(di_a), .di_b(di_b), .ana_in(ana_in),
		.diagnostic_interrupt_handler(handler), .di_image(di_image), .ana_image(ana_image), .irq(irq));

	rv_in_model i_rv_in_model (.real_di(real_di), .glitch_a(glitch_a), .stuck_hi_a(stuck_hi_a),
		.stuck_lo_b(stuck_lo_b), .ana_a(ana_a), .ana_b(ana_b), .di_a(di_a), .di_b(di_b), .ana_in(ana_in));

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	// extra edge so the register and irq have settled before anything is sampled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
		@(posedge clk_sys);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	task automatic tick();
		eval_tick <= 1'b1;
		@(posedge clk_sys);
		eval_tick <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic stop_test();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		stop_test();
	end

	initial begin
		do_reset();
		rchk(`RV_OFF_CTRL, 32'h4);
		rchk(`RV_OFF_DI_TIME, 32'ha);
		rchk(`RV_OFF_ANA_RANGE, 32'h7fff);
		rchk(8'h3c, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		wr(`RV_OFF_DI_TIME, 32'h2);
		wr(`RV_OFF_IRQ_ENABLE, 32'hf);
		real_di <= 16'h00f0;
		tick();
		chk({16'h0, di_image}, 32'h00f0);
		glitch_a <= 16'h0010;
		stuck_hi_a <= 16'h0001;
		tick();
		rchk(`RV_OFF_DI_DISC, 32'h11);
		chk({16'h0, di_image}, 32'h00f0);
		glitch_a <= 16'h0;
		tick();
		rchk(`RV_OFF_DI_DISC, 32'h1);
		chk({31'h0, irq}, 32'h0);
		tick();
		rchk(`RV_OFF_IRQ_STATUS, 32'h1);
		rchk(`RV_OFF_ERR_CODE, 32'd7960);
		rchk(`RV_OFF_DI_PASS_A, 32'h0);
		rchk(`RV_OFF_DI_PASS_B, 32'h0);
		chk({16'h0, di_image}, 32'h00f0);
		chk({31'h0, irq}, 32'h1);
		wr(`RV_OFF_IRQ_ENABLE, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(`RV_OFF_IRQ_ENABLE, 32'hf);
		real_di <= 16'h00f1;
		tick();
		rchk(`RV_OFF_DI_PASS_A, 32'h1);
		rchk(`RV_OFF_IRQ_STATUS, 32'h3);
		real_di <= 16'h00f0;
		tick();
		chk({16'h0, di_image}, 32'h00f0);
		wr(`RV_OFF_IRQ_CLEAR, 32'h3);
		chk({31'h0, irq}, 32'h0);
		rchk(`RV_OFF_IRQ_STATUS, 32'h0);
		rchk(`RV_OFF_IRQ_CLEAR, 32'h0);
		wr(`RV_OFF_ERR_CODE, 32'h0);
		rchk(`RV_OFF_ERR_CODE, 32'd7960);
		$display("test digital hold and localize done");
		// diagnostic-capable modules, reaction forces 0, applied value max
		wr(`RV_OFF_CTRL, 32'h7);
		real_di <= 16'h01f0;
		tick();
		chk({16'h0, di_image}, 32'h01f0);
		stuck_lo_b <= 16'h0100;
		repeat (3) tick();
		chk({16'h0, di_image}, 32'h00f0);
		rchk(`RV_OFF_IRQ_STATUS, 32'h1);
		real_di <= 16'h00f0;
		tick();
		rchk(`RV_OFF_DI_PASS_B, 32'h0);
		handler <= 1'b1;
		@(posedge clk_sys);
		handler <= 1'b0;
		@(posedge clk_sys);
		rchk(`RV_OFF_DI_PASS_B, 32'h100);
		real_di <= 16'h01f0;
		tick();
		chk({16'h0, di_image}, 32'h01f0);
		$display("test diagnostic passivation done");
		stuck_lo_b <= 16'h0;
		stuck_hi_a <= 16'h0;
		do_reset();
		rchk(`RV_OFF_ANA_TIME, 32'ha);
		wr(`RV_OFF_ANA_TIME, 32'h2);
		wr(`RV_OFF_IRQ_ENABLE, 32'hf);
		ana_a <= 16'd1000;
		ana_b <= 16'd2000;
		tick();
		chk({16'h0, ana_image}, 32'd2000);
		wr(`RV_OFF_CTRL, 32'h0);
		tick();
		chk({16'h0, ana_image}, 32'd1000);
		wr(`RV_OFF_CTRL, 32'h4);
		ana_b <= 16'd3000;
		tick();
		rchk(`RV_OFF_ANA_STATE, 32'h4);
		tick();
		chk({31'h0, irq}, 32'h0);
		tick();
		rchk(`RV_OFF_IRQ_STATUS, 32'hc);
		rchk(`RV_OFF_ANA_STATE, 32'h1);
		chk({31'h0, irq}, 32'h1);
		ana_b <= 16'd3100;
		tick();
		chk({16'h0, ana_image}, 32'd3100);
		do_reset();
		ana_b <= 16'h7fff;
		tick();
		rchk(`RV_OFF_ANA_STATE, 32'h2);
		rchk(`RV_OFF_IRQ_STATUS, 32'h8);
		chk({16'h0, ana_image}, 32'd1000);
		$display("test analog window done");
		stop_test();
	end
endmodule

//--- rtl/rv_cfg.svh
`ifndef RV_CFG_SVH
`define RV_CFG_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define RV_OFF_CTRL 8'h00
`define RV_OFF_DI_TIME 8'h04
`define RV_OFF_ANA_TIME 8'h08
`define RV_OFF_ANA_TOL 8'h0c
`define RV_OFF_ANA_RANGE 8'h10
`define RV_OFF_IRQ_STATUS 8'h14
`define RV_OFF_IRQ_CLEAR 8'h18
`define RV_OFF_IRQ_ENABLE 8'h1c
`define RV_OFF_ERR_CODE 8'h20
`define RV_OFF_DI_DISC 8'h24
`define RV_OFF_DI_PASS_A 8'h28
`define RV_OFF_DI_PASS_B 8'h2c
`define RV_OFF_ANA_STATE 8'h30
`define RV_OFF_DI_IMAGE 8'h34
`define RV_OFF_ANA_IMAGE 8'h38

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define RV_CTRL_DIAG 0
`define RV_CTRL_REACT 1
`define RV_CTRL_MAX 2
`define RV_IRQ_DI_EXP 0
`define RV_IRQ_DI_PASS 1
`define RV_IRQ_ANA_ERR 2
`define RV_IRQ_ANA_PASS 3
`define RV_CTRL_RST 3'h4
`define RV_DI_TIME_RST 16'h000a
`define RV_ANA_TIME_RST 16'h000a
`define RV_ANA_TOL_RST 7'h05
`define RV_ANA_RANGE_RST 16'h7fff
`define RV_PCT_SCALE 24'h000064
`define RV_ERR_DI_EXPIRED 16'h1f18
`define RV_ANA_OVF 16'h7fff
`define RV_ANA_UDF 16'h8000

`endif

//--- rtl/rv_pkg.sv
package rv_pkg;
	// evaluation state of one compared signal
	typedef enum logic [1:0] {RV_AGREE, RV_RUN, RV_EXPIRED} rv_st_t;

	typedef struct packed {
		logic [15:0] a;
		logic [15:0] b;
	} rv_ana_pair_t;
endpackage

//--- rtl/rv_voter.sv
`timescale 1ns/10ps
`include "rv_cfg.svh"
module rv_voter #(
	parameter int DI_W = 16,
	parameter int TW = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic eval_tick,
	input wire logic [DI_W-1:0] di_a,
	input wire logic [DI_W-1:0] di_b,
	input wire rv_pkg::rv_ana_pair_t ana_in,
	input wire logic diagnostic_interrupt_handler,
	output logic [DI_W-1:0] di_image,
	output logic [15:0] ana_image,
	output logic irq
);

	typedef struct packed {
		rv_pkg::rv_st_t [DI_W-1:0] di_st;
		logic [DI_W-1:0][TW-1:0] di_tmr;
		logic [DI_W-1:0] di_last;
		logic [DI_W-1:0] di_prev_a;
		logic [DI_W-1:0] di_prev_b;
		logic [DI_W-1:0] di_pass_a;
		logic [DI_W-1:0] di_pass_b;
		logic [DI_W-1:0] di_pend_a;
		logic [DI_W-1:0] di_pend_b;
		logic [DI_W-1:0] di_image;
		rv_pkg::rv_st_t ana_st;
		logic [TW-1:0] ana_tmr;
		logic [15:0] ana_last;
		logic [15:0] ana_image;
		logic ana_pass_a;
		logic ana_pass_b;
		logic [2:0] ctrl;
		logic [TW-1:0] di_time;
		logic [TW-1:0] ana_time;
		logic [6:0] tol;
		logic [15:0] range;
		logic [3:0] irq_st;
		logic [3:0] irq_en;
		logic [15:0] err_code;
		logic dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] hrdata;
	} rv_state_t;

	rv_state_t s;
	rv_state_t next_s;

	// ----------------------------------------
	// analog comparison helpers
	// ----------------------------------------
	logic [16:0] ana_diff;
	logic [16:0] ana_abs;
	logic [23:0] ana_lhs;
	logic [23:0] ana_rhs;
	logic ana_inside;
	logic ana_a_ge;
	logic [15:0] ana_applied;
	logic ovf_a;
	logic ovf_b;
	logic addr_ph;
	logic [DI_W-1:0] di_disc;

	assign ana_diff = $signed({ana_in.a[15], ana_in.a}) - $signed({ana_in.b[15], ana_in.b});
	assign ana_abs = ana_diff[16] ? 17'(-ana_diff) : ana_diff;
	// scale the difference instead of dividing the range: no divider, exact compare
	assign ana_lhs = 24'(ana_abs) * `RV_PCT_SCALE;
	assign ana_rhs = 24'(s.range) * 24'(s.tol);
	assign ana_inside = ana_lhs <= ana_rhs;
	assign ana_a_ge = $signed(ana_in.a) >= $signed(ana_in.b);
	assign ana_applied = (s.ctrl[`RV_CTRL_MAX] == ana_a_ge) ? ana_in.a : ana_in.b;
	assign ovf_a = ana_in.a == `RV_ANA_OVF || ana_in.a == `RV_ANA_UDF;
	assign ovf_b = ana_in.b == `RV_ANA_OVF || ana_in.b == `RV_ANA_UDF;
	assign addr_ph = hsel && hready && htrans[1];

	always_comb begin
		for (int i = 0; i < DI_W; i++) begin
			di_disc[i] = s.di_st[i] != rv_pkg::RV_AGREE;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic ta;
		logic tb;
		logic [3:0] ev;
		logic [DI_W-1:0] react;
		ta = 1'b0;
		tb = 1'b0;
		ev = 4'h0;
		next_s = s;
		react = '0;

		// ----------------------------------------
		// digital discrepancy, one lane per bit
		// ----------------------------------------
		// timing advances only on ticks, so detection may lag by up to one tick period
		if (eval_tick) begin
			for (int i = 0; i < DI_W; i++) begin
				react[i] = s.ctrl[`RV_CTRL_REACT] ? 1'b0 : s.di_last[i];
				next_s.di_prev_a[i] = di_a[i];
				next_s.di_prev_b[i] = di_b[i];
				if (s.di_pass_a[i] || s.di_pass_b[i]) begin
					next_s.di_image[i] = s.di_pass_a[i] ? di_b[i] : di_a[i];
				end else begin
					unique case (s.di_st[i])
						rv_pkg::RV_AGREE: begin
							if (di_a[i] == di_b[i]) begin
								next_s.di_image[i] = di_a[i];
								next_s.di_last[i] = di_a[i];
							end else begin
								// a stuck-high or stuck-low side shows up here as a mismatch
								next_s.di_st[i] = rv_pkg::RV_RUN;
								next_s.di_tmr[i] = '0;
								next_s.di_image[i] = s.di_last[i];
							end
						end
						rv_pkg::RV_RUN: begin
							if (di_a[i] == di_b[i]) begin
								next_s.di_st[i] = rv_pkg::RV_AGREE;
								next_s.di_tmr[i] = '0;
								next_s.di_image[i] = di_a[i];
								next_s.di_last[i] = di_a[i];
							end else if (({1'b0, s.di_tmr[i]} + (TW+1)'(1)) >= {1'b0, s.di_time}) begin
								next_s.di_st[i] = rv_pkg::RV_EXPIRED;
								ev[`RV_IRQ_DI_EXP] = 1'b1;
								next_s.di_image[i] = react[i];
							end else begin
								next_s.di_tmr[i] = s.di_tmr[i] + TW'(1);
								next_s.di_image[i] = s.di_last[i];
							end
						end
						rv_pkg::RV_EXPIRED: begin
							next_s.di_image[i] = react[i];
							ta = di_a[i] != s.di_prev_a[i];
							tb = di_b[i] != s.di_prev_b[i];
							if (ta && !tb && !s.di_pend_b[i]) begin
								if (s.ctrl[`RV_CTRL_DIAG]) begin
									next_s.di_pend_b[i] = 1'b1;
								end else begin
									next_s.di_pass_b[i] = 1'b1;
									next_s.di_image[i] = di_a[i];
									ev[`RV_IRQ_DI_PASS] = 1'b1;
								end
							end else if (tb && !ta && !s.di_pend_a[i]) begin
								if (s.ctrl[`RV_CTRL_DIAG]) begin
									next_s.di_pend_a[i] = 1'b1;
								end else begin
									next_s.di_pass_a[i] = 1'b1;
									next_s.di_image[i] = di_b[i];
									ev[`RV_IRQ_DI_PASS] = 1'b1;
								end
							end
						end
						default: begin
							next_s.di_st[i] = rv_pkg::RV_AGREE;
						end
					endcase
				end
			end
		end
		if (diagnostic_interrupt_handler && (|{s.di_pend_a, s.di_pend_b})) begin
			next_s.di_pass_a = next_s.di_pass_a | s.di_pend_a;
			next_s.di_pass_b = next_s.di_pass_b | s.di_pend_b;
			next_s.di_pend_a = next_s.di_pend_a & ~s.di_pend_a;
			next_s.di_pend_b = next_s.di_pend_b & ~s.di_pend_b;
			ev[`RV_IRQ_DI_PASS] = 1'b1;
		end

		// ----------------------------------------
		// analog tolerance window
		// ----------------------------------------
		if (eval_tick) begin
			if (ovf_a && !s.ana_pass_a) begin
				next_s.ana_pass_a = 1'b1;
				ev[`RV_IRQ_ANA_PASS] = 1'b1;
			end
			if (ovf_b && !s.ana_pass_b) begin
				next_s.ana_pass_b = 1'b1;
				ev[`RV_IRQ_ANA_PASS] = 1'b1;
			end
			if (next_s.ana_pass_a || next_s.ana_pass_b) begin
				next_s.ana_st = rv_pkg::RV_AGREE;
				next_s.ana_tmr = '0;
				if (!next_s.ana_pass_a) begin
					next_s.ana_image = ana_in.a;
				end else if (!next_s.ana_pass_b) begin
					next_s.ana_image = ana_in.b;
				end
			end else begin
				unique case (s.ana_st)
					rv_pkg::RV_AGREE: begin
						if (ana_inside) begin
							next_s.ana_image = ana_applied;
							next_s.ana_last = ana_applied;
						end else begin
							next_s.ana_st = rv_pkg::RV_RUN;
							next_s.ana_tmr = '0;
							next_s.ana_image = s.ana_last;
						end
					end
					rv_pkg::RV_RUN: begin
						if (ana_inside) begin
							next_s.ana_st = rv_pkg::RV_AGREE;
							next_s.ana_image = ana_applied;
							next_s.ana_last = ana_applied;
						end else if (({1'b0, s.ana_tmr} + (TW+1)'(1)) >= {1'b0, s.ana_time}) begin
							next_s.ana_st = rv_pkg::RV_AGREE;
							ev[`RV_IRQ_ANA_ERR] = 1'b1;
							ev[`RV_IRQ_ANA_PASS] = 1'b1;
							next_s.ana_image = ana_applied;
							if (ana_applied == ana_in.a) begin
								next_s.ana_pass_b = 1'b1;
							end else begin
								next_s.ana_pass_a = 1'b1;
							end
						end else begin
							next_s.ana_tmr = s.ana_tmr + TW'(1);
							next_s.ana_image = s.ana_last;
						end
					end
					default: begin
						next_s.ana_st = rv_pkg::RV_AGREE;
					end
				endcase
			end
		end

		// ----------------------------------------
		// bus slave: zero wait, read data latched in address phase
		// ----------------------------------------
		next_s.dp_wr = addr_ph && hwrite;
		next_s.dp_addr = haddr[7:0];
		if (addr_ph && !hwrite) begin
			unique case (haddr[7:0])
				`RV_OFF_CTRL: next_s.hrdata = 32'(s.ctrl);
				`RV_OFF_DI_TIME: next_s.hrdata = 32'(s.di_time);
				`RV_OFF_ANA_TIME: next_s.hrdata = 32'(s.ana_time);
				`RV_OFF_ANA_TOL: next_s.hrdata = 32'(s.tol);
				`RV_OFF_ANA_RANGE: next_s.hrdata = 32'(s.range);
				`RV_OFF_IRQ_STATUS: next_s.hrdata = 32'(s.irq_st);
				`RV_OFF_IRQ_ENABLE: next_s.hrdata = 32'(s.irq_en);
				`RV_OFF_ERR_CODE: next_s.hrdata = 32'(s.err_code);
				`RV_OFF_DI_DISC: next_s.hrdata = 32'(di_disc);
				`RV_OFF_DI_PASS_A: next_s.hrdata = 32'(s.di_pass_a);
				`RV_OFF_DI_PASS_B: next_s.hrdata = 32'(s.di_pass_b);
				`RV_OFF_ANA_STATE: next_s.hrdata = {29'h0, s.ana_st != rv_pkg::RV_AGREE, s.ana_pass_b, s.ana_pass_a};
				`RV_OFF_DI_IMAGE: next_s.hrdata = 32'(s.di_image);
				`RV_OFF_ANA_IMAGE: next_s.hrdata = 32'(s.ana_image);
				default: next_s.hrdata = 32'h0;
			endcase
		end
		if (s.dp_wr) begin
			unique case (s.dp_addr)
				`RV_OFF_CTRL: next_s.ctrl = hwdata[2:0];
				`RV_OFF_DI_TIME: next_s.di_time = hwdata[TW-1:0];
				`RV_OFF_ANA_TIME: next_s.ana_time = hwdata[TW-1:0];
				`RV_OFF_ANA_TOL: next_s.tol = hwdata[6:0];
				`RV_OFF_ANA_RANGE: next_s.range = hwdata[15:0];
				`RV_OFF_IRQ_ENABLE: next_s.irq_en = hwdata[3:0];
				default: ;
			endcase
		end
		// a new event in the clearing cycle survives the clear
		next_s.irq_st = s.irq_st & ~((s.dp_wr && s.dp_addr == `RV_OFF_IRQ_CLEAR) ? hwdata[3:0] : 4'h0);
		next_s.irq_st = next_s.irq_st | ev;
		if (ev[`RV_IRQ_DI_EXP]) begin
			next_s.err_code = `RV_ERR_DI_EXPIRED;
		end

		if (!rst_n) begin
			next_s = '0;
			next_s.ctrl = `RV_CTRL_RST;
			next_s.di_time = TW'(`RV_DI_TIME_RST);
			next_s.ana_time = TW'(`RV_ANA_TIME_RST);
			next_s.tol = `RV_ANA_TOL_RST;
			next_s.range = `RV_ANA_RANGE_RST;
		end
	end

	always_ff @(posedge clk_sys) begin
		s <= next_s;
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign di_image = s.di_image;
	assign ana_image = s.ana_image;
	assign irq = |(s.irq_st & s.irq_en);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_agree_image;
		@(posedge clk_sys) disable iff (!rst_n)
		eval_tick && (s.di_pass_a | s.di_pass_b) == '0 && di_a == di_b |=> di_image == $past(di_a);
	endproperty
	a_agree_image: assert property (p_agree_image) else $error("agreeing inputs not imaged");

	property p_first_disc;
		@(posedge clk_sys) disable iff (!rst_n)
		eval_tick && s.di_st[0] == rv_pkg::RV_AGREE && !s.di_pass_a[0] && !s.di_pass_b[0] && di_a[0] != di_b[0]
		|=> s.di_st[0] == rv_pkg::RV_RUN && s.di_tmr[0] == '0 && di_disc[0];
	endproperty
	a_first_disc: assert property (p_first_disc) else $error("first mismatch not flagged");

	property p_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		eval_tick && s.di_st[0] == rv_pkg::RV_RUN && !s.di_pass_a[0] && !s.di_pass_b[0] && di_a[0] != di_b[0]
		&& ({1'b0, s.di_tmr[0]} + (TW+1)'(1)) < {1'b0, s.di_time} |=> di_image[0] == $past(s.di_last[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("held value lost while timing");

	property p_expire;
		@(posedge clk_sys) disable iff (!rst_n)
		eval_tick && s.di_st[0] == rv_pkg::RV_RUN && !s.di_pass_a[0] && !s.di_pass_b[0] && di_a[0] != di_b[0]
		&& ({1'b0, s.di_tmr[0]} + (TW+1)'(1)) >= {1'b0, s.di_time}
		|=> s.err_code == `RV_ERR_DI_EXPIRED && s.irq_st[`RV_IRQ_DI_EXP] && s.di_st[0] == rv_pkg::RV_EXPIRED;
	endproperty
	a_expire: assert property (p_expire) else $error("expiry not reported");

	property p_no_pass;
		@(posedge clk_sys) disable iff (!rst_n)
		s.di_st[0] == rv_pkg::RV_RUN ##1 s.di_st[0] == rv_pkg::RV_EXPIRED |-> !s.di_pass_a[0] && !s.di_pass_b[0];
	endproperty
	a_no_pass: assert property (p_no_pass) else $error("expiry passivated a channel");

	property p_localize;
		@(posedge clk_sys) disable iff (!rst_n)
		eval_tick && s.di_st[0] == rv_pkg::RV_EXPIRED && !s.ctrl[`RV_CTRL_DIAG] && !s.di_pass_a[0]
		&& !s.di_pass_b[0] && !s.di_pend_a[0] && di_b[0] != s.di_prev_b[0] && di_a[0] == s.di_prev_a[0]
		|=> s.di_pass_a[0] && !s.di_pass_b[0] && di_image[0] == $past(di_b[0]);
	endproperty
	a_localize: assert property (p_localize) else $error("wrong side passivated");

	property p_diag;
		@(posedge clk_sys) disable iff (!rst_n)
		(|s.di_pend_b) && !diagnostic_interrupt_handler
		|=> ((s.di_pass_b & ~$past(s.di_pass_b)) & $past(s.di_pend_b)) == '0;
	endproperty
	a_diag: assert property (p_diag) else $error("passivated before handler call");

	property p_overflow;
		@(posedge clk_sys) disable iff (!rst_n)
		eval_tick && (ana_in.b == `RV_ANA_OVF || ana_in.b == `RV_ANA_UDF) |=> s.ana_pass_b ##1 s.ana_pass_b;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow channel kept active");

	property p_clear;
		@(posedge clk_sys) disable iff (!rst_n)
		eval_tick && s.di_st[0] == rv_pkg::RV_RUN && !s.di_pass_a[0] && !s.di_pass_b[0] && di_a[0] == di_b[0]
		|=> s.di_st[0] == rv_pkg::RV_AGREE && s.di_tmr[0] == '0 && !di_disc[0];
	endproperty
	a_clear: assert property (p_clear) else $error("flag or timer not cleared");

endmodule
